// File: sbc_mode_sequencer.sv
/*
  Operating-mode sequencer: reset pulse, normal request timeout,
  normal/stop/sleep modes, switch, hall supply, mux and gain settings.
  Assumes analog pins (undervoltage, watchdog config, PWM, wake inputs,
  SPI) are asynchronous; the watchdog failure pulse is on this clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sbc_mode_sequencer #(
  parameter int RESET_CYCLES = sbc_pkg::RESET_PULSE_CYC,
  parameter int NREQ_CYCLES  = sbc_pkg::NREQ_TIMEOUT_CYC,
  parameter int CYC_PERIOD   = 4096,
  parameter int SENSE_ON     = 64
) (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_clk_en,
  // spi pins
  input  wire logic       i_sclk,
  input  wire logic       i_mosi,
  input  wire logic       i_cs_n,
  output logic            o_miso,
  output logic            o_miso_oe,
  // supervision
  input  wire logic       i_vdd_uv,
  input  wire logic       i_wd_fail,
  input  wire logic       i_watchdog_config_pin_gnd,
  // pins
  input  wire logic       i_pwm_input_pin,
  input  wire logic [3:0] i_wake_in,
  // supply, reset and lin control
  output logic            o_mcu_rst_n,
  output logic            o_vdd_on,
  output logic            o_vdd_limited,
  output logic            o_lin_tx_en,
  output logic            o_lin_rx_only,
  output logic            o_irq_n,
  // switches and analog settings
  output logic [1:0]      o_high_side_sw,
  output logic [1:0]      o_low_side_sw,
  output logic            o_hall_sensor_supply_on,
  output logic [2:0]      o_analog_mux_sel,
  output logic [3:0]      o_div_connect,
  output logic [1:0]      o_sense_gain,
  output logic [2:0]      o_op_state
);
  typedef enum {st_reset, st_nreq, st_normal, st_stop, st_sleep} op_state_e;

  op_state_e  state_q, state_d;
  logic [31:0] timer_q, timer_d;
  logic        tim_wr_q, tim_wr_d, irq_q, irq_d;
  logic [3:0]  high_q, high_d, low_q, low_d, hall_q, hall_d;
  logic [2:0]  mux_q, mux_d;
  logic [15:0] cyc_q, cyc_d;
  logic [2:0]  meta_q, sync_q, meta_d, sync_d;
  sbc_pkg::ctl_out_s out_q, out_d;

  sbc_pkg::spi_frame_s frame;
  logic        frame_valid, cs_rise, pin_wake, uv_s, wd_gnd_s, pwm_s;
  logic        wr, rd_status, active, low_power, cyc_en, sense_on, sample;
  logic        go_normal, reset_done, nreq_expire;
  logic [3:0]  wake_level;
  logic [1:0]  mode_bits;

  sbc_spi_rx u_spi (
    .i_clock       (i_clock),
    .i_rst_n       (i_rst_n),
    .i_clk_en      (i_clk_en),
    .i_sclk        (i_sclk),
    .i_mosi        (i_mosi),
    .i_cs_n        (i_cs_n),
    .o_miso        (o_miso),
    .o_miso_oe     (o_miso_oe),
    .i_tx_byte     ({o_op_state, irq_q, wake_level}), // [RULE11]
    .o_frame       (frame),
    .o_frame_valid (frame_valid),
    .o_cs_rise     (cs_rise)
  );

  sbc_wake_detect u_wake (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .i_pins   (i_wake_in),
    .i_mask   (sbc_pkg::mux_wake_mask(mux_q)),
    .i_arm    (low_power),
    .i_cyclic (high_q[sbc_pkg::HS_CYCLIC_BIT]),
    .i_sample (sample),
    .o_level  (wake_level),
    .o_wake   (pin_wake)
  );

  // asynchronous level inputs
  always_comb begin
    meta_d = {i_vdd_uv, i_watchdog_config_pin_gnd, i_pwm_input_pin};
    sync_d = meta_q;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else if (i_clk_en) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign uv_s      = sync_q[2];
  assign wd_gnd_s  = sync_q[1];
  assign pwm_s     = sync_q[0];
  assign wr        = frame_valid && frame.write;
  assign rd_status = frame_valid && !frame.write &&
                     frame.addr == sbc_pkg::ADDR_STATUS;
  assign mode_bits = frame.data[1:0];
  assign active    = state_q == st_nreq || state_q == st_normal;
  assign low_power = state_q == st_stop || state_q == st_sleep;
  assign cyc_en    = low_power && high_q[sbc_pkg::HS_CYCLIC_BIT];
  assign sense_on  = cyc_en && cyc_q >= 16'(CYC_PERIOD - SENSE_ON);
  assign sample    = cyc_en && cyc_q == 16'(CYC_PERIOD - 1);

  // timing control must precede the normal command, in an earlier frame
  assign go_normal = wr && frame.addr == sbc_pkg::ADDR_MODE &&
                     mode_bits == sbc_pkg::MODE_NORMAL &&
                     (tim_wr_q || state_q == st_normal); // [RULE8]
  assign reset_done  = timer_q == 32'(RESET_CYCLES - 1); // [RULE22]
  assign nreq_expire = timer_q == 32'(NREQ_CYCLES - 1); // [RULE22]

  // mode state and timers
  always_comb begin
    state_d  = state_q;
    tim_wr_d = tim_wr_q;
    irq_d    = irq_q && !rd_status;
    case (state_q)
      st_reset: begin
        tim_wr_d = 1'b0;
        irq_d    = 1'b0;
        if (reset_done && !uv_s) begin
          state_d = wd_gnd_s ? st_normal : st_nreq; // [RULE4] [RULE6] [RULE10]
        end
      end
      st_nreq: begin
        if (wr && frame.addr == sbc_pkg::ADDR_TIMING) begin
          tim_wr_d = 1'b1; // [RULE8]
        end
        if (uv_s || i_wd_fail || nreq_expire) begin
          state_d = st_reset; // [RULE5] [RULE9]
        end else if (go_normal) begin
          state_d = st_normal; // [RULE3]
        end
      end
      st_normal: begin
        if (uv_s || i_wd_fail) begin
          state_d = st_reset; // [RULE5]
        end else if (wr && frame.addr == sbc_pkg::ADDR_MODE) begin
          if (mode_bits == sbc_pkg::MODE_STOP) begin
            state_d = st_stop; // [RULE3] [RULE1]
          end else if (mode_bits == sbc_pkg::MODE_SLEEP) begin
            state_d = st_sleep; // [RULE3] [RULE1]
          end
        end
      end
      st_stop: begin
        if (uv_s) begin
          state_d = st_reset; // [RULE5]
        end else if (pin_wake || cs_rise) begin
          state_d  = st_nreq; // [RULE6] [RULE21]
          tim_wr_d = 1'b0;
          // set wins over a same-cycle status read; cs wake is silent
          irq_d    = pin_wake; // [RULE2]
        end
      end
      st_sleep: begin
        // supply is down, so undervoltage and spi are ignored here
        if (pin_wake) begin
          state_d = st_reset; // [RULE2] [RULE5]
        end
      end
      default: state_d = st_reset;
    endcase
    if (state_d != state_q || (state_q == st_reset && uv_s)) begin
      timer_d = 32'h0;
    end else if (state_q == st_reset || state_q == st_nreq) begin
      timer_d = timer_q + 32'h1;
    end else begin
      timer_d = timer_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q  <= st_reset;
      timer_q  <= 32'h0;
      tim_wr_q <= 1'b0;
      irq_q    <= 1'b0;
    end else if (i_clk_en) begin
      state_q  <= state_d;
      timer_q  <= timer_d;
      tim_wr_q <= tim_wr_d;
      irq_q    <= irq_d;
    end
  end

  // configuration, writable only while powered up and running
  always_comb begin
    high_d = high_q;
    low_d  = low_q;
    mux_d  = mux_q;
    hall_d = hall_q;
    if (state_q == st_reset) begin
      high_d = 4'h0;
      low_d  = 4'h0;
      mux_d  = 3'h0;
      hall_d = 4'h0;
    end else if (wr && active) begin
      case (frame.addr)
        sbc_pkg::ADDR_HIGH: high_d = frame.data; // [RULE17]
        sbc_pkg::ADDR_LOW:  low_d  = frame.data; // [RULE16]
        sbc_pkg::ADDR_MUX:  mux_d  = frame.data[2:0]; // [RULE14]
        sbc_pkg::ADDR_HALL: hall_d = frame.data; // [RULE18] [RULE19]
        default: ;
      endcase
    end
    // cyclic sense timebase, free-running only in low power
    if (cyc_en) begin
      cyc_d = (cyc_q == 16'(CYC_PERIOD - 1)) ? 16'h0 : cyc_q + 16'h1;
    end else begin
      cyc_d = 16'h0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      high_q <= 4'h0;
      low_q  <= 4'h0;
      mux_q  <= 3'h0;
      hall_q <= 4'h0;
      cyc_q  <= 16'h0;
    end else if (i_clk_en) begin
      high_q <= high_d;
      low_q  <= low_d;
      mux_q  <= mux_d;
      hall_q <= hall_d;
      cyc_q  <= cyc_d;
    end
  end

  // registered pin controls
  always_comb begin
    out_d.mcu_rst_n   = state_q != st_reset; // [RULE4] [RULE7]
    out_d.vdd_on      = state_q != st_sleep; // [RULE1]
    out_d.vdd_limited = state_q == st_stop; // [RULE1]
    out_d.lin_tx_en   = state_q == st_normal;
    out_d.lin_rx_only = state_q == st_nreq || state_q == st_stop; // [RULE7]
    out_d.hall_on     = state_q == st_normal &&
                        hall_q[sbc_pkg::HALL_ON_BIT]; // [RULE18]
    out_d.div_connect = sbc_pkg::mux_wake_mask(mux_q); // [RULE15]
    out_d.high_side   = 2'h0;
    out_d.low_side    = 2'h0;
    if (active) begin
      out_d.high_side = high_q[1:0] &
        {2{!high_q[sbc_pkg::SW_PWM_BIT] || pwm_s}}; // [RULE17]
      out_d.low_side  = low_q[1:0] &
        {2{!low_q[sbc_pkg::SW_PWM_BIT] || pwm_s}}; // [RULE16]
    end else if (sense_on) begin
      out_d.high_side = high_q[1:0]; // [RULE12] [RULE17]
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_q <= '0;
    end else if (i_clk_en) begin
      out_q <= out_d;
    end
  end

  assign o_mcu_rst_n             = out_q.mcu_rst_n;
  assign o_vdd_on                = out_q.vdd_on;
  assign o_vdd_limited           = out_q.vdd_limited;
  assign o_lin_tx_en             = out_q.lin_tx_en;
  assign o_lin_rx_only           = out_q.lin_rx_only;
  assign o_high_side_sw          = out_q.high_side;
  assign o_low_side_sw           = out_q.low_side;
  assign o_hall_sensor_supply_on = out_q.hall_on;
  assign o_div_connect           = out_q.div_connect;
  assign o_irq_n                 = !irq_q;
  assign o_analog_mux_sel        = mux_q;
  assign o_sense_gain            = hall_q[sbc_pkg::GAIN_LSB +: 2]; // [RULE19]
  assign o_op_state              = 3'(state_q);

  a_sleep_vdd_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_q == st_sleep && i_clk_en) |=> !o_vdd_on) // [RULE1]
    else $error("supply still on in sleep");
  a_stop_wake_irq: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_q == st_stop && pin_wake && !uv_s)
      |=> state_q == st_nreq && !o_irq_n) // [RULE2]
    else $error("stop wake without interrupt");
  a_reset_line_low: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_q == st_reset && i_clk_en) |=> !o_mcu_rst_n) // [RULE4]
    else $error("reset line high during reset");
  a_reset_pulse_end: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_q == st_reset && reset_done && !uv_s && i_clk_en)
      |=> state_q != st_reset) // [RULE4]
    else $error("reset pulse did not end on count");
  a_uv_forces_reset: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (uv_s && state_q != st_sleep && i_clk_en) |=> state_q == st_reset) // [RULE5]
    else $error("undervoltage did not force reset");
  a_nreq_outputs: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_q == st_nreq && i_clk_en)
      |=> o_vdd_on && o_mcu_rst_n && o_lin_rx_only && !o_lin_tx_en) // [RULE7]
    else $error("wrong pin state in normal request");
  a_nreq_timeout: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_q == st_nreq && nreq_expire && i_clk_en)
      |=> state_q == st_reset) // [RULE9]
    else $error("normal request timeout missed");
  a_wd_bypass: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ($past(state_q) == st_reset && state_q != st_reset && $past(wd_gnd_s))
      |-> state_q == st_normal) // [RULE10]
    else $error("grounded watchdog pin did not skip request");
  a_hall_in_normal: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(o_hall_sensor_supply_on) |-> $past(state_q) == st_normal) // [RULE18]
    else $error("hall supply on outside normal mode");
endmodule
`default_nettype wire

// File: sbc_pkg.sv
/*
  Constants, frame layout and output carrier for the operating-mode
  sequencer. Assumes a 250 MHz internal clock and an 8-bit SPI frame
  laid out as write flag, 3-bit address, 4-bit data.
*/
//
// Behaviour
// RULE1: one full run mode plus stop (supply limited) and sleep (supply off).
// RULE2: stop exit raises wake interrupt; sleep exit goes through reset. Only a wake-pin stop exit raises it here; a chip select wake is silent.
// RULE3: host picks the mode with the two mode select bits over SPI.
// RULE4: after power-up hold reset line low 1.0 ms, then go normal request.
// RULE5: undervoltage, watchdog failure, sleep wake or timeout force reset.
// RULE6: normal request follows reset end or a stop wake automatically.
// RULE7: normal request keeps supply on, reset high, LIN receive only.
// RULE8: normal request starts 150 ms; host writes timing and mode zero.
// RULE9: timer expiry without normal command returns to reset.
// RULE10: grounded watchdog config pin skips normal request after reset.
// RULE11: wake inputs readable over SPI and wake the part in low power.
// RULE12: cyclic sense pulses high sides, samples inputs, change wakes.
// RULE13: without cyclic sense a plain input change wakes stop or sleep.
// RULE14: mux-selected wake input is no digital input and never wakes.
// RULE15: scaling divider connected only while that input is selected.
// RULE16: low side switches under SPI, optionally following the PWM pin.
// RULE17: high sides under SPI or PWM, and usable for cyclic sensing.
// RULE18: hall supply switched by SPI only while in normal mode.
// RULE19: SPI setting selects the current sense amplifier gain.
// RULE20: frames are exactly 8 bits, latched on chip select rising edge.
// RULE21: chip select rising edge wakes the part from stop.
// RULE22: reset pulse and timeout counted with parameterised counts.
`default_nettype none
package sbc_pkg;
  localparam int CLK_MHZ          = 250;
  localparam int RESET_PULSE_US   = 1000;
  localparam int NREQ_TIMEOUT_MS  = 150;
  localparam int RESET_PULSE_CYC  = RESET_PULSE_US * CLK_MHZ;
  localparam int NREQ_TIMEOUT_CYC = NREQ_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int FRAME_BITS       = 8;
  localparam int WAKE_INPUTS      = 4;

  // mode select field values
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STOP   = 2'h1;
  localparam logic [1:0] MODE_SLEEP  = 2'h2;

  // frame addresses
  localparam logic [2:0] ADDR_MODE   = 3'h0;
  localparam logic [2:0] ADDR_TIMING = 3'h1;
  localparam logic [2:0] ADDR_HIGH   = 3'h2;
  localparam logic [2:0] ADDR_LOW    = 3'h3;
  localparam logic [2:0] ADDR_MUX    = 3'h4;
  localparam logic [2:0] ADDR_HALL   = 3'h5;
  localparam logic [2:0] ADDR_STATUS = 3'h6;

  // field positions inside the 4-bit data
  localparam int SW_PWM_BIT    = 2;
  localparam int HS_CYCLIC_BIT = 3;
  localparam int HALL_ON_BIT   = 0;
  localparam int GAIN_LSB      = 1;

  typedef struct packed {
    logic       write;
    logic [2:0] addr;
    logic [3:0] data;
  } spi_frame_s;

  typedef struct packed {
    logic       mcu_rst_n;
    logic       vdd_on;
    logic       vdd_limited;
    logic       lin_tx_en;
    logic       lin_rx_only;
    logic [1:0] high_side;
    logic [1:0] low_side;
    logic       hall_on;
    logic [3:0] div_connect;
  } ctl_out_s;

  // mux code n+1 selects wake input n; other codes select none of them
  function automatic logic [3:0] mux_wake_mask(input logic [2:0] sel);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < WAKE_INPUTS; i++) begin
      if (sel == 3'(i + 1)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction
endpackage
`default_nettype wire

// File: sbc_spi_rx.sv
/*
  SPI slave shifter: 8-bit frames, sampled on SCLK falling edge,
  answer shifted out on rising edge. Assumes SCLK is much slower than
  the system clock; all pins are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
module sbc_spi_rx (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_clk_en,
  // pins
  input  wire logic              i_sclk,
  input  wire logic              i_mosi,
  input  wire logic              i_cs_n,
  output logic                   o_miso,
  output logic                   o_miso_oe,
  // user side
  input  wire logic [7:0]        i_tx_byte,
  output sbc_pkg::spi_frame_s    o_frame,
  output logic                   o_frame_valid,
  output logic                   o_cs_rise
);
  logic [2:0] meta_q, sync_q, last_q;
  logic [2:0] meta_d, sync_d, last_d;
  logic [7:0] rx_q, rx_d, tx_q, tx_d;
  logic [3:0] cnt_q, cnt_d;
  logic       miso_q, miso_d, oe_q, oe_d, fv_q, fv_d, rise_q, rise_d;
  sbc_pkg::spi_frame_s frame_q, frame_d;

  always_comb begin
    meta_d  = {i_cs_n, i_sclk, i_mosi};
    sync_d  = meta_q;
    last_d  = sync_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    cnt_d   = cnt_q;
    miso_d  = miso_q;
    oe_d    = !sync_q[2];
    fv_d    = 1'b0;
    rise_d  = 1'b0;
    frame_d = frame_q;
    if (last_q[2] && !sync_q[2]) begin
      cnt_d = 4'h0;
      tx_d  = i_tx_byte;
    end else if (!sync_q[2]) begin
      if (last_q[1] && !sync_q[1]) begin
        rx_d = {rx_q[6:0], sync_q[0]};
        // saturate so long frames never alias back to a legal count
        if (cnt_q != 4'hf) begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      if (!last_q[1] && sync_q[1]) begin
        miso_d = tx_q[7];
        tx_d   = {tx_q[6:0], 1'b0};
      end
    end else if (!last_q[2] && sync_q[2]) begin
      rise_d  = 1'b1;
      fv_d    = (cnt_q == 4'(sbc_pkg::FRAME_BITS)); // [RULE20]
      frame_d = rx_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q  <= 3'h7;
      sync_q  <= 3'h7;
      last_q  <= 3'h7;
      rx_q    <= 8'h00;
      tx_q    <= 8'h00;
      cnt_q   <= 4'h0;
      miso_q  <= 1'b0;
      oe_q    <= 1'b0;
      fv_q    <= 1'b0;
      rise_q  <= 1'b0;
      frame_q <= '0;
    end else if (i_clk_en) begin
      meta_q  <= meta_d;
      sync_q  <= sync_d;
      last_q  <= last_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      cnt_q   <= cnt_d;
      miso_q  <= miso_d;
      oe_q    <= oe_d;
      fv_q    <= fv_d;
      rise_q  <= rise_d;
      frame_q <= frame_d;
    end
  end

  assign o_miso        = miso_q;
  assign o_miso_oe     = oe_q;
  assign o_frame       = frame_q;
  assign o_frame_valid = fv_q && i_clk_en;
  assign o_cs_rise     = rise_q && i_clk_en;

  a_frame_length: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_frame_valid |-> o_cs_rise && cnt_q == 4'h8) // [RULE20]
    else $error("frame accepted with wrong bit count");
endmodule
`default_nettype wire

// File: sbc_wake_detect.sv
/*
  Wake input conditioner: synchronises the wake pins, blanks inputs
  routed to the analog mux, and flags level changes either
  continuously or between two cyclic-sense samples.
*/
`timescale 1ns/100ps
`default_nettype none
module sbc_wake_detect (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_clk_en,
  // pins and control
  input  wire logic [3:0] i_pins,
  input  wire logic [3:0] i_mask,
  input  wire logic       i_arm,
  input  wire logic       i_cyclic,
  input  wire logic       i_sample,
  // results
  output logic [3:0]      o_level,
  output logic            o_wake
);
  logic [3:0] meta_q, sync_q, prev_q, samp_q, level_q;
  logic [3:0] meta_d, sync_d, prev_d, samp_d, level_d;
  logic       valid_q, valid_d, wake_q, wake_d;
  logic [3:0] diff_c, diff_s;

  always_comb begin
    meta_d  = i_pins;
    sync_d  = meta_q;
    prev_d  = sync_q;
    level_d = sync_q & ~i_mask; // [RULE11] [RULE14]
    diff_c  = (sync_q ^ prev_q) & ~i_mask; // [RULE14]
    diff_s  = (sync_q ^ samp_q) & ~i_mask;
    samp_d  = samp_q;
    valid_d = valid_q && i_arm && i_cyclic;
    wake_d  = 1'b0;
    if (i_arm && i_cyclic) begin
      if (i_sample) begin
        samp_d  = sync_q;
        valid_d = 1'b1;
        wake_d  = valid_q && (diff_s != 4'h0); // [RULE12]
      end
    end else if (i_arm) begin
      wake_d = (diff_c != 4'h0); // [RULE13]
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q  <= 4'h0;
      sync_q  <= 4'h0;
      prev_q  <= 4'h0;
      samp_q  <= 4'h0;
      level_q <= 4'h0;
      valid_q <= 1'b0;
      wake_q  <= 1'b0;
    end else if (i_clk_en) begin
      meta_q  <= meta_d;
      sync_q  <= sync_d;
      prev_q  <= prev_d;
      samp_q  <= samp_d;
      level_q <= level_d;
      valid_q <= valid_d;
      wake_q  <= wake_d;
    end
  end

  assign o_level = level_q;
  assign o_wake  = wake_q && i_clk_en;

  a_masked_level: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_clk_en ##1 $stable(i_mask) |-> (o_level & i_mask) == 4'h0) // [RULE14]
    else $error("mux-selected wake input still reads as digital");
endmodule
`default_nettype wire

// File: sbc_host_model.sv
/* host side spi master model, 8-bit frames msb first.
   assumes 64 ns sclk, started off a system clock edge. */
`timescale 1ns/100ps
`default_nettype none
module sbc_host_model (
  // spi pins
  output logic       o_sclk,
  output logic       o_mosi,
  output logic       o_cs_n,
  input  wire logic  i_miso,
  // last byte shifted back by the device
  output logic [7:0] o_rx
);
  initial begin
    o_sclk = 1'b0;
    o_mosi = 1'b0;
    o_cs_n = 1'b1;
    o_rx   = 8'h00;
  end
  // exactly eight bits, latched by cs rising
  task automatic send(input logic [7:0] b);
    o_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #32 o_sclk = 1'b1;
      o_mosi = b[i];
      #32 o_sclk = 1'b0;
      // device moves miso on the rising edge, so take it here
      o_rx = {o_rx[6:0], i_miso};
    end
    #32 o_cs_n = 1'b1;
    // released data line must not look valid
    o_mosi = ~o_mosi;
    #64;
  endtask
endmodule
`default_nettype wire

// File: sbc_mode_sequencer_bench.sv
/* self-checking bench of the mode sequencer.
   assumes short sim counts and the host model on spi. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("Error %0t got %h exp %h", $time, g, e); end end
module sbc_mode_sequencer_bench;
  logic       clock, rst_n, uv, wd_fail, wd_gnd, pwm;
  logic       sclk, mosi, cs_n, vdd_on, vlim, tx_en, rx_only;
  logic       mcu_rst_n, irq_n, hall;
  logic       clk_en, miso, miso_oe;
  logic [7:0] rx;
  logic [3:0] wake, div;
  logic [1:0] hs, ls, gain;
  logic [2:0] mux, state;
  int         failures, total_checks;
  sbc_host_model host (.o_sclk(sclk), .o_mosi(mosi), .o_cs_n(cs_n),
    .i_miso(miso), .o_rx(rx));
  // request timeout must outlast a status read plus two frames
  sbc_mode_sequencer #(.RESET_CYCLES(20), .NREQ_CYCLES(600),
    .CYC_PERIOD(32), .SENSE_ON(4)) DUT (
    .i_clock(clock), .i_rst_n(rst_n), .i_clk_en(clk_en),
    .i_sclk(sclk), .i_mosi(mosi), .i_cs_n(cs_n), .o_miso(miso),
    .o_miso_oe(miso_oe), .i_vdd_uv(uv), .i_wd_fail(wd_fail),
    .i_watchdog_config_pin_gnd(wd_gnd), .i_pwm_input_pin(pwm),
    .i_wake_in(wake), .o_mcu_rst_n(mcu_rst_n), .o_vdd_on(vdd_on),
    .o_vdd_limited(vlim), .o_lin_tx_en(tx_en),
    .o_lin_rx_only(rx_only), .o_irq_n(irq_n), .o_high_side_sw(hs),
    .o_low_side_sw(ls), .o_hall_sensor_supply_on(hall),
    .o_analog_mux_sel(mux), .o_div_connect(div),
    .o_sense_gain(gain), .o_op_state(state));
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [2:0] a, input logic [3:0] d);
    host.send({1'b1, a, d});
    cyc(8);
  endtask
  task automatic await_st(input logic [2:0] s);
    for (int i = 0; i < 600 && state !== s; i++) cyc(1);
    // pin outputs follow the state one clock later
    cyc(1);
    `CHK(state, s)
  endtask
  task automatic go_normal;
    wr(sbc_pkg::ADDR_TIMING, 4'h0);
    wr(sbc_pkg::ADDR_MODE, sbc_pkg::MODE_NORMAL);
    await_st(3'h2);
  endtask
  task automatic t_power_up;
    cyc(10);
    `CHK(mcu_rst_n, 1'b0)
    `CHK(vdd_on, 1'b1)
    clk_en = 1'b0;
    cyc(30);
    `CHK(state, 3'h0)
    clk_en = 1'b1;
    await_st(3'h1);
    `CHK(mcu_rst_n, 1'b1)
    `CHK(rx_only, 1'b1)
  endtask
  task automatic t_timeout;
    wr(sbc_pkg::ADDR_MODE, sbc_pkg::MODE_NORMAL);
    `CHK(state, 3'h1)
    await_st(3'h0);
    `CHK(mcu_rst_n, 1'b0)
    await_st(3'h1);
  endtask
  task automatic t_config;
    go_normal();
    `CHK(tx_en, 1'b1)
    wr(sbc_pkg::ADDR_HALL, 4'h5);
    `CHK({hall, gain}, 3'h6)
    wr(sbc_pkg::ADDR_HIGH, 4'h2);
    `CHK(hs, 2'h2)
    wr(sbc_pkg::ADDR_LOW, 4'h5);
    `CHK(ls, 2'h0)
    pwm = 1'b1;
    cyc(6);
    `CHK(ls, 2'h1)
    wr(sbc_pkg::ADDR_MUX, 4'h2);
    `CHK(div, 4'h2)
    `CHK(mux, 3'h2)
  endtask
  task automatic t_stop;
    wr(sbc_pkg::ADDR_MODE, sbc_pkg::MODE_STOP);
    await_st(3'h3);
    `CHK(vlim, 1'b1)
    `CHK(hall, 1'b0)
    wake[1] = ~wake[1];
    cyc(40);
    `CHK(state, 3'h3)
    wake[2] = ~wake[2];
    await_st(3'h1);
    `CHK(irq_n, 1'b0)
    host.send(8'h60);
    cyc(8);
    `CHK(irq_n, 1'b1)
    `CHK(rx, 8'h34)
    `CHK(miso_oe, 1'b0)
    go_normal();
    wr(sbc_pkg::ADDR_MODE, sbc_pkg::MODE_STOP);
    await_st(3'h3);
    host.send(8'h60);
    await_st(3'h1);
    `CHK(irq_n, 1'b1)
  endtask
  task automatic t_sleep;
    go_normal();
    wr(sbc_pkg::ADDR_HIGH, 4'h9);
    wr(sbc_pkg::ADDR_MODE, sbc_pkg::MODE_SLEEP);
    await_st(3'h4);
    `CHK(vdd_on, 1'b0)
    // let the first cyclic sample arm before the input moves
    cyc(40);
    wake[0] = ~wake[0];
    await_st(3'h0);
  endtask
  task automatic t_faults;
    await_st(3'h1);
    go_normal();
    uv = 1'b1;
    cyc(4);
    uv = 1'b0;
    await_st(3'h0);
    await_st(3'h1);
    go_normal();
    wd_fail = 1'b1;
    cyc(1);
    wd_fail = 1'b0;
    await_st(3'h0);
    wd_gnd = 1'b1;
    await_st(3'h2);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // generous bound; the sequence needs roughly 20 us
  initial begin
    #300000;
    failures++;
    stop_test();
  end
  initial begin
    {rst_n, uv, wd_fail, wd_gnd, pwm, wake} = 9'h0;
    clk_en = 1'b1;
    cyc(12);
    rst_n = 1'b1;
    t_power_up();
    t_timeout();
    t_config();
    t_stop();
    t_sleep();
    t_faults();
    stop_test();
  end
endmodule
`default_nettype wire
